/* File: event_match_pkg.sv */
// Constants, field layouts and carrier types of the event match combiner.
// Assumes one 40 MHz clock shared with the observed processor bus.
package event_match_pkg;
    localparam int NUM_DET = 16;
    localparam int NUM_PATH = 9;
    localparam int LIB_MAX = 256;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_SEL = 8'h08;
    localparam logic [7:0] OFF_DCFG = 8'h0C;
    localparam logic [7:0] OFF_ALO = 8'h10;
    localparam logic [7:0] OFF_AHI = 8'h14;
    localparam logic [7:0] OFF_ADD = 8'h18;
    localparam logic [7:0] OFF_DLY = 8'h1C;
    localparam logic [7:0] OFF_SEQ = 8'h20;
    localparam logic [7:0] OFF_SLO = 8'h24;
    localparam logic [7:0] OFF_SHI = 8'h28;
    localparam logic [7:0] OFF_LIB = 8'h2C;
    localparam logic [7:0] OFF_PATH = 8'h40;
    // CTRL fields
    localparam int C_OR = 0;
    localparam int C_OTH = 1;
    localparam int C_MODE = 2;
    localparam int C_APPLY = 5;
    localparam int C_TMODE = 6;
    localparam int C_ROUTE = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0101;
    // Detector config fields, also used by the ADD command
    localparam int D_EN = 0;
    localparam int D_ORM = 1;
    localparam int D_TYPE = 2;
    localparam int D_RANGE = 4;
    localparam int D_RD = 5;
    localparam int D_WR = 6;
    localparam int D_SIZE = 7;
    localparam int D_IRQS = 9;
    localparam int D_IRQR = 10;
    localparam int D_TRIG = 11;
    localparam int D_CFGW = 12;
    localparam int A_QUICK = 12;
    localparam int A_TRACE = 13;
    localparam int A_VAR = 14;
    localparam logic [1:0] T_FETCH = 2'h0;
    localparam logic [1:0] T_DATA = 2'h1;
    localparam logic [1:0] T_IRQ = 2'h2;
    localparam logic [1:0] T_TRIG = 2'h3;
    localparam logic [1:0] SZ_ANY = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] TM_FILL_STOP = 2'h0;
    localparam logic [1:0] TM_FILL_FULL = 2'h1;
    // Status fields; error bits 0 to 3 are write one to clear
    localparam int S_EFULL = 0;
    localparam int S_ESIZE = 1;
    localparam int S_ETRACE = 2;
    localparam int S_ELIB = 3;
    localparam int S_COND = 4;
    localparam int S_HALT = 5;
    localparam int S_HITS = 16;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    localparam logic [1:0] ST_DONE = 2'h3;

    typedef enum logic [4:0] {
        M_ACC = 5'h01, M_SIM = 5'h02, M_SUB = 5'h04,
        M_SEQ = 5'h08, M_STT = 5'h10
    } mode_e;
    typedef enum logic [2:0] {
        ST_S0 = 3'h1, ST_S1 = 3'h2, ST_S2 = 3'h4
    } stt_e;

    typedef struct packed {
        logic exec_v;
        logic [31:0] exec_pc;
        logic acc_v;
        logic [31:0] acc_addr;
        logic acc_rd;
        logic acc_wr;
        logic [1:0] acc_size;
        logic irq_enter;
        logic irq_exit;
    } cpu_obs_s;

    typedef struct packed {
        logic brk;
        logic trc;
        logic perf;
    } route_s;
endpackage

/* File: debug_event_match_combiner.sv */
// Event detection and combination unit of an in-circuit emulator.
// Assumes the observed bus runs on aclk; trig_pin is asynchronous.
// Operation
// - Sixteen independent, freely assignable event detectors.
// - Fetch detector fires on executed programmed address.
// - Prefetch bus cycles never fire fetch detectors.
// - Data detector matches address or range plus qualifiers.
// - Interrupt detector sees servicing start and return.
// - Trigger detector fires while pin in programmed state.
// - OR mode fires on any enabled detector with its OR bit set.
// - Accumulating AND latches hits until all seen.
// - Simultaneous AND needs all hits same cycle.
// - Subroutine mode: chosen hit inside address range.
// - Sequential mode: hits in programmed order.
// - State mode walks diagram to terminal condition.
// - Combined condition routed to break, trace, performance.
// - Seventeenth armed event rejected with error flag.
// - Quick fetch event joins OR set if free.
// - Variable events take size; only 1-2 bytes.
// - Saved event store holds at most 256 entries.
// - No quick trace points in fill trace modes.
// - Break halt delayed 0 to 65535 cycles.
// - Three states, nine paths, plus reset point.
// - OR combination enabled after reset.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module debug_event_match_combiner
    import event_match_pkg::*;
#(
    parameter int DLY_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cpu_obs_s cpu,
    input wire logic trig_pin,
    input wire logic run_start,
    output route_s cond_out,
    output logic halt_req
);
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return old;
    endfunction

    function automatic logic in_rng(input logic [31:0] a,
            input logic [31:0] lo, input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    logic [D_CFGW-1:0] cfg_q [NUM_DET];
    logic [31:0] lo_q [NUM_DET];
    logic [31:0] hi_q [NUM_DET];
    logic [8:0] path_q [NUM_PATH];
    logic [31:0] ctrl_q, alo_q, ahi_q, seq_q, slo_q, shi_q;
    logic [3:0] sel_q;
    logic [DLY_W-1:0] dly_q, cnt_q;
    logic [8:0] lib_q;
    logic [3:0] err_q;
    logic t1_q, t2_q;
    logic [NUM_DET-1:0] hit_q, acc_q, en_v, hit_d;
    logic [1:0] ptr_q;
    stt_e stt_q;
    logic halt_pend_q, cond_q;
    logic wr_go, rd_go, clr;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_seen_q, w_seen_q;

    // AXI write: both channels captured, then one register update
    assign wr_go = aw_seen_q && w_seen_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_seen_q <= 1'b0;
            w_seen_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            s_axi_awready <= !aw_seen_q && s_axi_awvalid && !s_axi_awready;
            s_axi_wready <= !w_seen_q && s_axi_wvalid && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_seen_q <= 1'b1;
                waddr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_seen_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_seen_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_seen_q <= 1'b0;
            end
        end
    end

    logic wmapped;
    assign wmapped = (waddr_q <= OFF_LIB) ||
        ((waddr_q >= OFF_PATH) && (waddr_q < OFF_PATH + 8'(4*NUM_PATH)));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wmapped && waddr_q[1:0] == 2'h0) ?
                RESP_OK : RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Free slot search for the ADD command
    logic free_ok;
    logic [3:0] free_idx;
    always_comb begin
        free_ok = 1'b0;
        free_idx = 4'h0;
        for (int i = NUM_DET - 1; i >= 0; i--) begin
            if (!cfg_q[i][D_EN]) begin
                free_ok = 1'b1;
                free_idx = 4'(i);
            end
        end
    end

    logic [31:0] wv;
    logic add_bad_sz, add_bad_tr, add_go;
    assign wv = wdata_q;
    assign add_bad_sz = wv[A_VAR] && (wv[D_SIZE +: 2] != SZ_BYTE) &&
        (wv[D_SIZE +: 2] != SZ_WORD);
    assign add_bad_tr = wv[A_TRACE] &&
        ((ctrl_q[C_TMODE +: 2] == TM_FILL_STOP) ||
         (ctrl_q[C_TMODE +: 2] == TM_FILL_FULL));
    assign add_go = wr_go && waddr_q == OFF_ADD && free_ok &&
        !add_bad_sz && !add_bad_tr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            alo_q <= 32'h0000_0000;
            ahi_q <= 32'h0000_0000;
            seq_q <= 32'h0000_0000;
            slo_q <= 32'h0000_0000;
            shi_q <= 32'h0000_0000;
            sel_q <= 4'h0;
            dly_q <= '0;
        end else begin
            ctrl_q[C_APPLY] <= 1'b0;
            if (wr_go && waddr_q == OFF_CTRL) begin
                ctrl_q <= merge(ctrl_q, wv, wstrb_q);
            end else if (add_go && wv[A_QUICK]) begin
                ctrl_q[C_OR] <= 1'b1;
            end
            if (wr_go && waddr_q == OFF_ALO) alo_q <= merge(alo_q, wv, wstrb_q);
            if (wr_go && waddr_q == OFF_AHI) ahi_q <= merge(ahi_q, wv, wstrb_q);
            if (wr_go && waddr_q == OFF_SEQ) seq_q <= merge(seq_q, wv, wstrb_q);
            if (wr_go && waddr_q == OFF_SLO) slo_q <= merge(slo_q, wv, wstrb_q);
            if (wr_go && waddr_q == OFF_SHI) shi_q <= merge(shi_q, wv, wstrb_q);
            if (wr_go && waddr_q == OFF_SEL) sel_q <= wv[3:0];
            if (wr_go && waddr_q == OFF_DLY) dly_q <= wv[DLY_W-1:0];
        end
    end

    // Detector table; slots are addressed directly or by ADD
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_DET; i++) begin
                cfg_q[i] <= '0;
                lo_q[i] <= 32'h0000_0000;
                hi_q[i] <= 32'h0000_0000;
            end
        end else if (wr_go && waddr_q == OFF_DCFG) begin
            cfg_q[sel_q] <= wv[D_CFGW-1:0];
            lo_q[sel_q] <= alo_q;
            hi_q[sel_q] <= ahi_q;
        end else if (add_go) begin
            cfg_q[free_idx] <= wv[D_CFGW-1:0] |
                (D_CFGW'(wv[A_QUICK]) << D_ORM);
            cfg_q[free_idx][D_EN] <= 1'b1;
            lo_q[free_idx] <= alo_q;
            hi_q[free_idx] <= ahi_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NUM_PATH; i++) begin
                path_q[i] <= 9'h000;
            end
        end else begin
            for (int i = 0; i < NUM_PATH; i++) begin
                if (wr_go && waddr_q == OFF_PATH + 8'(4*i)) begin
                    path_q[i] <= wv[8:0];
                end
            end
        end
    end

    // Saved event store occupancy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lib_q <= 9'h000;
        end else if (wr_go && waddr_q == OFF_LIB) begin
            if (wv[0] && lib_q < 9'(LIB_MAX)) begin
                lib_q <= lib_q + 9'h001;
            end else if (!wv[0] && lib_q != 9'h000) begin
                lib_q <= lib_q - 9'h001;
            end
        end
    end

    // Sticky errors; a new error wins over a clear in the same cycle
    logic [3:0] err_set;
    assign err_set[S_EFULL] = wr_go && waddr_q == OFF_ADD && !free_ok;
    assign err_set[S_ESIZE] = wr_go && waddr_q == OFF_ADD && add_bad_sz;
    assign err_set[S_ETRACE] = wr_go && waddr_q == OFF_ADD && add_bad_tr;
    assign err_set[S_ELIB] = wr_go && waddr_q == OFF_LIB && wv[0] &&
        lib_q >= 9'(LIB_MAX);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 4'h0;
        end else begin
            if (wr_go && waddr_q == OFF_STAT) begin
                err_q <= (err_q & ~wv[3:0]) | err_set;
            end else begin
                err_q <= err_q | err_set;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OK;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OK;
                s_axi_rdata <= 32'h0000_0000;
                if (s_axi_araddr == OFF_CTRL) begin
                    s_axi_rdata <= ctrl_q;
                end else if (s_axi_araddr == OFF_STAT) begin
                    s_axi_rdata <= {hit_q, 10'h000, halt_pend_q, cond_q,
                        err_q};
                end else if (s_axi_araddr == OFF_SEL) begin
                    s_axi_rdata <= {28'h0000000, sel_q};
                end else if (s_axi_araddr == OFF_DCFG) begin
                    s_axi_rdata <= 32'(cfg_q[sel_q]);
                end else if (s_axi_araddr == OFF_ALO) begin
                    s_axi_rdata <= alo_q;
                end else if (s_axi_araddr == OFF_AHI) begin
                    s_axi_rdata <= ahi_q;
                end else if (s_axi_araddr == OFF_ADD) begin
                    s_axi_rdata <= {27'h0000000, free_ok, free_idx};
                end else if (s_axi_araddr == OFF_DLY) begin
                    s_axi_rdata <= 32'(dly_q);
                end else if (s_axi_araddr == OFF_SEQ) begin
                    s_axi_rdata <= seq_q;
                end else if (s_axi_araddr == OFF_SLO) begin
                    s_axi_rdata <= slo_q;
                end else if (s_axi_araddr == OFF_SHI) begin
                    s_axi_rdata <= shi_q;
                end else if (s_axi_araddr == OFF_LIB) begin
                    s_axi_rdata <= 32'(lib_q);
                end else if (s_axi_araddr >= OFF_PATH &&
                        s_axi_araddr < OFF_PATH + 8'(4*NUM_PATH) &&
                        s_axi_araddr[1:0] == 2'h0) begin
                    s_axi_rdata <= 32'(path_q[4'(
                        (s_axi_araddr - OFF_PATH) >> 2)]);
                end else begin
                    s_axi_rresp <= RESP_ERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Trigger pin synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t1_q <= 1'b0;
            t2_q <= 1'b0;
        end else begin
            t1_q <= trig_pin;
            t2_q <= t1_q;
        end
    end

    // Per-detector match
    always_comb begin
        for (int i = 0; i < NUM_DET; i++) begin
            en_v[i] = cfg_q[i][D_EN];
            hit_d[i] = 1'b0;
            case (cfg_q[i][D_TYPE +: 2])
                T_FETCH: hit_d[i] = cpu.exec_v &&
                    cpu.exec_pc == lo_q[i];
                T_DATA: hit_d[i] = cpu.acc_v &&
                    (cfg_q[i][D_RANGE] ?
                        in_rng(cpu.acc_addr, lo_q[i], hi_q[i]) :
                        cpu.acc_addr == lo_q[i]) &&
                    ((cfg_q[i][D_RD] && cpu.acc_rd) ||
                     (cfg_q[i][D_WR] && cpu.acc_wr)) &&
                    (cfg_q[i][D_SIZE +: 2] == SZ_ANY ||
                     cfg_q[i][D_SIZE +: 2] == cpu.acc_size);
                T_IRQ: hit_d[i] = (cfg_q[i][D_IRQS] && cpu.irq_enter) ||
                    (cfg_q[i][D_IRQR] && cpu.irq_exit);
                T_TRIG: hit_d[i] = t2_q == cfg_q[i][D_TRIG];
                default: hit_d[i] = 1'b0;
            endcase
            hit_d[i] = hit_d[i] && en_v[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_q <= '0;
        end else begin
            hit_q <= hit_d;
        end
    end

    // Progress clears on apply and on program start
    assign clr = ctrl_q[C_APPLY] || run_start;

    logic [NUM_DET-1:0] orm_v;
    always_comb begin
        for (int i = 0; i < NUM_DET; i++) begin
            orm_v[i] = cfg_q[i][D_ORM];
        end
    end

    mode_e mode;
    always_comb begin
        case (ctrl_q[C_MODE +: 3])
            3'h0: mode = M_ACC;
            3'h1: mode = M_SIM;
            3'h2: mode = M_SUB;
            3'h3: mode = M_SEQ;
            default: mode = M_STT;
        endcase
    end

    logic [3:0] step_det;
    logic seq_last, rst_pt, pc_in_q;
    assign step_det = seq_q[4*ptr_q +: 4];
    assign seq_last = ptr_q == seq_q[17:16];
    assign rst_pt = seq_q[24] && hit_q[seq_q[23:20]];
    // Last executed PC, aligned in time with the registered hits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_in_q <= 1'b0;
        end else if (cpu.exec_v) begin
            pc_in_q <= in_rng(cpu.exec_pc, slo_q, shi_q);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q | (hit_q & en_v);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clr || rst_pt) begin
            ptr_q <= 2'h0;
        end else if (mode == M_SEQ && hit_q[step_det]) begin
            ptr_q <= seq_last ? 2'h0 : ptr_q + 2'h1;
        end
    end

    // Path table: first enabled path from current state wins
    stt_e stt_d;
    logic stt_fire;
    always_comb begin
        stt_d = stt_q;
        stt_fire = 1'b0;
        for (int p = NUM_PATH - 1; p >= 0; p--) begin
            if (path_q[p][8] && hit_q[path_q[p][3:0]] &&
                    stt_q[path_q[p][5:4]]) begin
                stt_fire = path_q[p][7:6] == ST_DONE;
                case (path_q[p][7:6])
                    2'h1: stt_d = ST_S1;
                    2'h2: stt_d = ST_S2;
                    default: stt_d = ST_S0;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || clr || rst_pt) begin
            stt_q <= ST_S0;
        end else if (mode == M_STT) begin
            stt_q <= stt_d;
        end
    end

    logic or_c, oth_c, cond_d;
    always_comb begin
        or_c = ctrl_q[C_OR] && |(hit_q & orm_v & en_v);
        case (mode)
            M_ACC: oth_c = en_v != '0 &&
                ((acc_q | hit_q) & en_v) == en_v;
            M_SIM: oth_c = en_v != '0 && (hit_q & en_v) == en_v;
            M_SUB: oth_c = pc_in_q && hit_q[seq_q[3:0]];
            M_SEQ: oth_c = seq_last && hit_q[step_det];
            M_STT: oth_c = stt_fire;
            default: oth_c = 1'b0;
        endcase
        cond_d = or_c || (ctrl_q[C_OTH] && oth_c);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_q <= 1'b0;
            cond_out <= '0;
        end else begin
            cond_q <= cond_d;
            cond_out.brk <= cond_d && ctrl_q[C_ROUTE];
            cond_out.trc <= cond_d && ctrl_q[C_ROUTE+1];
            cond_out.perf <= cond_d && ctrl_q[C_ROUTE+2];
        end
    end

    // Break delay; later conditions while counting are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            halt_pend_q <= 1'b0;
            cnt_q <= '0;
            halt_req <= 1'b0;
        end else begin
            halt_req <= 1'b0;
            if (!halt_pend_q) begin
                if (cond_out.brk) begin
                    halt_pend_q <= 1'b1;
                    cnt_q <= dly_q;
                end
            end else if (cnt_q == '0) begin
                halt_pend_q <= 1'b0;
                halt_req <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

/* File: event_match_asserts.sv */
// Port checks of the event match combiner.
// Bound into the top module; one aclk domain.
`timescale 1ns/1ps
module event_match_asserts
    import event_match_pkg::*;
#(
    parameter int DLY_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire route_s cond_out,
    input wire logic halt_req
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_B_AFTER: assert property (both_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_R_AFTER: assert property (read_taken |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    AST_AW_ONE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than a cycle");
    AST_AR_ONE: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than a cycle");
    AST_HALT_ONE: assert property (halt_req |=> !halt_req)
        else $error("halt request longer than a cycle");
    AST_RST_QUIET: assert property ($rose(aresetn)
        |-> cond_out == 3'h0 && !halt_req)
        else $error("outputs active out of reset");
endmodule

bind debug_event_match_combiner event_match_asserts #(.DLY_W(DLY_W)) chk_u (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .cond_out, .halt_req);

/* File: cpu_bus_model.sv */
// Behavioural processor bus and trigger line seen by the combiner.
// Changes outputs just after aclk edges; the bench calls cycle.
`timescale 1ns/1ps
module cpu_bus_model
    import event_match_pkg::*;
(
    input wire logic aclk,
    output cpu_obs_s cpu,
    output logic trig_pin
);
    initial begin
        cpu = '0;
        trig_pin = 1'b0;
    end
    // Idle address fields inverted so a stale value never matches
    task cycle(input logic ex, input logic ac, input logic [31:0] a);
        begin
            @(posedge aclk);
            cpu.exec_v <= ex;
            cpu.exec_pc <= ex ? a : ~a;
            cpu.acc_v <= ac;
            cpu.acc_rd <= ac;
            cpu.acc_addr <= a;
            cpu.acc_size <= SZ_WORD;
            @(posedge aclk);
            cpu.exec_v <= 1'b0;
            cpu.acc_v <= 1'b0;
            cpu.acc_rd <= 1'b0;
            cpu.exec_pc <= ~a;
            cpu.acc_addr <= ~a;
        end
    endtask
endmodule

/* File: debug_event_match_combiner_bench.sv */
// Self-checking bench: registers, fetch match, routing, halt, limits.
// One 40 MHz clock drives the combiner and the bus model.
`timescale 1ns/1ps
module debug_event_match_combiner_bench;
    import event_match_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, run_start, trig_pin, halt_req;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    cpu_obs_s cpu;
    route_s cond_out;
    int failures, checks;
    debug_event_match_combiner #(.DLY_W(16)) dut_u (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpu, .trig_pin, .run_start, .cond_out, .halt_req);
    cpu_bus_model mcpu (.aclk, .cpu, .trig_pin);
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task at(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw, pb, ha, hw, hb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        {pa, pw, pb} = 3'h7;
        while (pa || pw || pb) begin
            @(negedge aclk);
            ha = s_axi_awready && pa;
            hw = s_axi_wready && pw;
            hb = s_axi_bvalid && pb;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) s_axi_bready <= 1'b0;
            pa = pa && !ha;
            pw = pw && !hw;
            pb = pb && !hb;
        end
        chk("bresp", 32'(er), 32'(r));
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        logic pa, hr, hv;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        {pa, hv} = 2'h2;
        while (!hv) begin
            @(negedge aclk);
            hr = s_axi_arready && pa;
            hv = s_axi_rvalid;
            v = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (hr) s_axi_arvalid <= 1'b0;
            if (hv) s_axi_rready <= 1'b0;
            pa = pa && !hr;
        end
        chk("rresp", 32'(er), 32'(r));
    endtask
    task results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // Whole run is well under two thousand cycles
    initial begin
        #100000;
        failures++;
        results();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, run_start} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFF_CTRL, RESP_OK);
        chk("ctrl", CTRL_RST, v);
        rd(8'h30, RESP_ERR);
        chk("unmapped", 32'h0, v);
        wr(8'h30, 32'hFFFF_FFFF, RESP_ERR);
        wr(OFF_SEL, 32'h0, RESP_OK);
        wr(OFF_ALO, 32'h0000_0100, RESP_OK);
        wr(OFF_DCFG, 32'h0000_0003, RESP_OK);
        mcpu.cycle(1'b0, 1'b1, 32'h0000_0100);
        at(1);
        chk("prefetch", 32'h0, 32'(cond_out));
        for (int i = 0; i < 3; i++) begin
            wr(OFF_CTRL, 32'h1 | (32'h100 << i), RESP_OK);
            mcpu.cycle(1'b1, 1'b0, 32'h0000_0100);
            at(1);
            chk("route", 32'h4 >> i, 32'(cond_out));
            at(2);
            chk("halt", 32'(i == 0), 32'(halt_req));
        end
        for (int j = 0; j < 16; j++) begin
            if (j == 15) rd(OFF_STAT, RESP_OK);
            if (j == 15) chk("room", 32'h0, 32'(v[S_EFULL]));
            wr(OFF_ADD, 32'h0000_0001, RESP_OK);
        end
        rd(OFF_STAT, RESP_OK);
        chk("full", 32'h1, 32'(v[S_EFULL]));
        @(posedge aclk);
        aresetn <= 1'b0;
        at(3);
        @(posedge aclk);
        aresetn <= 1'b1;
        wr(OFF_ADD, 32'h0000_2001, RESP_OK);
        wr(OFF_ADD, 32'h0000_4005, RESP_OK);
        rd(OFF_STAT, RESP_OK);
        chk("errors", 32'h6, 32'(v[2:0]));
        wr(OFF_DCFG, 32'h0000_000F, RESP_OK);
        at(3);
        chk("trigger", 32'h4, 32'(cond_out));
        results();
    end
endmodule
